// file: src/nca_pkg.sv
// Constants, encodings and timing counts for the contactless command arbiter.
// Assumes a single 50 MHz clock; every user writes nca_pkg::name, nothing is imported.
//
// Summary of operation
// - Multi-page read returns four bytes per page
// - No answer before minimum delay; reader times out
// - Read start: 00-E9, EC, ED, sector1, SRAM
// - Invalid read start page answers negative acknowledge
// - Invalid pages inside a read return zeros
// - Page write stores four bytes at page
// - Write pages 02-E9, sector1, SRAM when passing
// - Out-of-range write: negative acknowledge, memory untouched
// - Locked pages are never modified; the SRAM burst writes without checking page_locked_in
// - SRAM burst F0-FF, active with pass-through only
// - Sector switch uses two packets, acknowledge between
// - Successful switch: silence longer than one millisecond
// - Memory goes to first requesting side only
// - Two lock status bits, both clear at reset
// - Host lock: session reads and switch still allowed
// - Host lock: memory commands get special refusal
// - Reader lock: host session register access allowed
// - Reader lock: other host accesses get not-acknowledge
// - Idle reader plus host address sets host lock
// - Reader lock clears on field loss, halt, completion
package nca_pkg;
  // ==========================================================
  // Command codes and page map
  localparam logic [7:0] OP_MULTI_READ = 8'h3A;
  localparam logic [7:0] OP_PAGE_WRITE = 8'hA2;
  localparam logic [7:0] OP_SRAM_BURST = 8'hA6;
  localparam logic [7:0] OP_SECTOR_SW = 8'hC2;
  localparam logic [7:0] SECTOR_KEY = 8'hFF;        // Second byte of first switch packet
  localparam logic [7:0] PG_WR_FIRST = 8'h02;
  localparam logic [7:0] PG_SEC0_LAST = 8'hE9;
  localparam logic [7:0] PG_SESS_A = 8'hEC;         // Session register pages
  localparam logic [7:0] PG_SESS_B = 8'hED;
  localparam logic [7:0] PG_SRAM_FIRST = 8'hF0;
  localparam logic [7:0] PG_SRAM_LAST = 8'hFF;
  // ==========================================================
  // Frame lengths in bytes, CRC excluded
  localparam logic [6:0] LEN_READ = 7'h03;
  localparam logic [6:0] LEN_WRITE = 7'h06;
  localparam logic [6:0] LEN_BURST = 7'h43;
  localparam logic [6:0] LEN_SW1 = 7'h02;
  localparam logic [6:0] LEN_SW2 = 7'h04;
  // ==========================================================
  // Four-bit answers and the lock reset value
  localparam logic [3:0] RESP_ACK = 4'hA;
  localparam logic [3:0] NAK_INVALID = 4'h0;
  localparam logic [3:0] NAK_ARBITER = 4'h4;        // Distinct code for a memory held by host
  localparam logic LOCK_RESET = 1'b0;
  // ==========================================================
  // Buffer shape: bit 8 marks a four-bit answer
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int RESP_N = 9;                        // Frame delay index
  localparam int CARRIER_KHZ = 13560;
  localparam int RESP_MIN_NS = ((RESP_N * 128 + 84) * 1000000 + CARRIER_KHZ - 1) / CARRIER_KHZ;
  localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int QUIET_MIN_US = 1000;
  localparam int QUIET_MIN_CYC = QUIET_MIN_US * 1000 / CLK_NS + 1;  // Strictly longer
  // ==========================================================
  // Command sequencer states
  typedef enum logic [3:0] {
    NCA_IDLE = 4'h0, NCA_RX = 4'h1, NCA_FETCH = 4'h2, NCA_WAIT = 4'h3,
    NCA_CAP = 4'h4, NCA_PUSH = 4'h5, NCA_WCHK = 4'h6, NCA_WDO = 4'h7,
    NCA_REPLY = 4'h8, NCA_SW2 = 4'h9, NCA_QUIET = 4'hA, NCA_DRAIN = 4'hB
  } nca_state_t;
endpackage

// file: src/nca_stream_if.sv
// Answer stream between the sequencer and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface nca_stream_if;
  logic wr_valid;                                   // Producer offers a word
  logic wr_ready;                                   // Buffer has room
  logic [nca_pkg::FIFO_WIDTH-1:0] wr_data;
  logic rd_valid;                                   // Buffer not empty
  logic rd_ready;                                   // Consumer takes the head
  logic [nca_pkg::FIFO_WIDTH-1:0] rd_data;
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
  modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
endinterface

// file: src/nca_fifo.sv
// First-in first-out buffer for answer bytes, width and depth set by parameters.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module nca_fifo #(
  parameter int WIDTH = nca_pkg::FIFO_WIDTH,
  parameter int DEPTH = nca_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  nca_stream_if.store s_if
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // State
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;               // Storage, read from a register
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } nca_fifo_t;
  nca_fifo_t s;
  nca_fifo_t next_s;
  logic push;
  logic pop;
  // Honest flags straight from the count
  assign s_if.wr_ready = (s.count != AW'(0) + (AW+1)'(DEPTH));
  assign s_if.rd_valid = (s.count != '0);
  assign s_if.rd_data = s.mem[s.rp];
  assign push = s_if.wr_valid && s_if.wr_ready;
  assign pop = s_if.rd_ready && s_if.rd_valid;
  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = s_if.wr_data;
      next_s.wp = s.wp + AW'(1);
    end
    if (pop) begin
      next_s.rp = s.rp + AW'(1);
    end
    // Simultaneous push and pop leave the count alone
    next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  // Register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // nca_fifo

// file: src/nca_timer.sv
// One-shot cycle counter: done rises a fixed count after a start pulse.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module nca_timer #(
  parameter int CYCLES = nca_pkg::RESP_MIN_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  output logic done_out
);
  typedef struct packed {
    logic [16:0] cnt;
    logic done;
  } nca_timer_t;
  nca_timer_t s;
  nca_timer_t next_s;
  assign done_out = s.done;
  // ==========================================================
  // Countdown; a restart drops done at once
  always_comb begin
    next_s = s;
    if (start_in) begin
      next_s.cnt = 17'(CYCLES);
      next_s.done = 1'b0;
    end else if (s.cnt == 17'h0_001) begin
      next_s.cnt = '0;
      next_s.done = 1'b1;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 17'h0_001;
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // nca_timer

// file: src/nca_arbiter.sv
// Contactless command sequencer with memory arbitration against the wired host.
// Assumes decoded frames arrive byte by byte on this clock, CRC already checked,
// and that memory read data is valid the cycle after the read strobe is seen.
`timescale 1ns/1ps
module nca_arbiter #(
  parameter int RESP_CYC = nca_pkg::RESP_MIN_CYC,
  parameter int QUIET_CYC = nca_pkg::QUIET_MIN_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic rx_valid_in,                     // One frame byte
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_end_in,                       // Frame complete pulse
  input wire logic rx_crc_ok_in,                    // CRC good, valid with rx_end_in
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_nibble_out,                       // Data low four bits are an answer code
  input wire logic field_on_in,
  input wire logic halt_in,                         // Halt command seen
  input wire logic active_state_in,                 // Reader side in active state
  input wire logic pthru_on_in,
  input wire logic large_variant_in,                // Second sector present
  input wire logic [31:0] mem_rd_data_in,
  input wire logic page_locked_in,                  // Lock state of page at mem_addr_out
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [8:0] mem_addr_out,                  // {sector, page}
  output logic [31:0] mem_wdata_out,                // First received byte in bits 31:24
  input wire logic i2c_addr_match_in,               // Own address after START
  input wire logic i2c_release_in,                  // Host sequence end or watchdog
  input wire logic i2c_access_in,                   // Host read or write request
  input wire logic i2c_reg_access_in,               // That request is a register command
  output logic i2c_nack_out,
  output logic i2c_lock_out,
  output logic reader_side_lock_out,
  output logic sector_out
);
  // ==========================================================
  // State
  typedef struct packed {
    nca_pkg::nca_state_t st;
    logic [6:0] cnt;                                // Bytes in current frame
    logic [7:0] op, a1, a2, page, last; // Command, arguments, read cursor and end
    logic [31:0] word, wdata; // Assembly and shift word; write data
    logic [1:0] bsel;
    logic [3:0] code;                               // Pending four-bit answer
    logic burst_ok, sw_pending, sector; // Pending: switch awaits second packet
    logic i2c_lock, reader_side_lock, i2c_nack;
    logic rd, wr, pv, resp_go, quiet_go, tv;
    logic flush; // Dropping buffered words after an abort
    logic [8:0] addr, pd, td;
  } nca_arb_t;
  nca_arb_t s;
  nca_arb_t next_s;
  nca_stream_if fq ();
  logic resp_done, quiet_done, pop;

  nca_fifo #(.WIDTH(nca_pkg::FIFO_WIDTH), .DEPTH(nca_pkg::FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .s_if(fq.store)
  );
  nca_timer #(.CYCLES(RESP_CYC)) u_resp (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(s.resp_go),
    .done_out(resp_done)
  );
  nca_timer #(.CYCLES(QUIET_CYC)) u_quiet (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(s.quiet_go),
    .done_out(quiet_done)
  );

  // ==========================================================
  // Page checks
  // Read start pages; SRAM lives in sector 0 only
  function automatic logic rd_ok(input logic sec, input logic [7:0] p, input logic pt, big);
    rd_ok = sec ? big : ((p <= nca_pkg::PG_SEC0_LAST) || (p == nca_pkg::PG_SESS_A) ||
      (p == nca_pkg::PG_SESS_B) || (pt && p >= nca_pkg::PG_SRAM_FIRST));
  endfunction
  // Writable pages
  function automatic logic wr_ok(input logic sec, input logic [7:0] p, input logic pt, big);
    wr_ok = sec ? big : ((p >= nca_pkg::PG_WR_FIRST && p <= nca_pkg::PG_SEC0_LAST) ||
      (pt && p >= nca_pkg::PG_SRAM_FIRST));
  endfunction
  function automatic logic sess_pg(input logic sec, input logic [7:0] p);
    sess_pg = !sec && (p == nca_pkg::PG_SESS_A || p == nca_pkg::PG_SESS_B);
  endfunction

  // Buffer hookup; outside an abort flush the pop only happens once the answer delay has run out
  assign fq.wr_valid = s.pv;
  assign fq.wr_data = s.pd;
  assign pop = fq.rd_valid && (s.flush || ((!s.tv || tx_ready_in) && resp_done));
  assign fq.rd_ready = pop;
  assign tx_valid_out = s.tv;
  assign tx_data_out = s.td[7:0];
  assign tx_nibble_out = s.td[8];
  assign mem_rd_out = s.rd;
  assign mem_wr_out = s.wr;
  assign mem_addr_out = s.addr;
  assign mem_wdata_out = s.wdata;
  assign i2c_nack_out = s.i2c_nack;
  assign i2c_lock_out = s.i2c_lock;
  assign reader_side_lock_out = s.reader_side_lock;
  assign sector_out = s.sector;

  // ==========================================================
  // Sequencer, output stage and lock bits
  always_comb begin
    next_s = s;
    next_s.rd = 1'b0;
    next_s.wr = 1'b0;
    next_s.resp_go = 1'b0;
    next_s.quiet_go = 1'b0;
    // Accepted word moves the producer on
    next_s.pv = s.pv && !fq.wr_ready;
    // Abort flush runs until the buffer is empty
    next_s.flush = s.flush && fq.rd_valid;
    case (s.st)
      nca_pkg::NCA_IDLE, nca_pkg::NCA_RX, nca_pkg::NCA_SW2: begin
        if (rx_valid_in) begin
          next_s.st = (s.st == nca_pkg::NCA_SW2) ? nca_pkg::NCA_SW2 : nca_pkg::NCA_RX;
          next_s.cnt = (s.cnt == 7'h7F) ? s.cnt : s.cnt + 7'h01;
          case (s.cnt)
            7'h00: next_s.op = rx_byte_in;
            7'h01: next_s.a1 = rx_byte_in;
            7'h02: next_s.a2 = rx_byte_in;
            default: next_s.a2 = s.a2;
          endcase
          next_s.word = {s.word[23:0], rx_byte_in};
          // Burst legal once both bounds are known
          if (s.cnt == 7'h02 && s.op == nca_pkg::OP_SRAM_BURST) begin
            next_s.burst_ok = active_state_in && pthru_on_in && !s.sector && !s.i2c_lock &&
                              s.a1 == nca_pkg::PG_SRAM_FIRST &&
                              rx_byte_in == nca_pkg::PG_SRAM_LAST;
            next_s.page = nca_pkg::PG_SRAM_FIRST;
          end
          // Burst pages go out as each fourth data byte lands
          if (s.burst_ok && s.cnt >= 7'h06 && s.cnt < nca_pkg::LEN_BURST &&
              s.cnt[1:0] == 2'b10) begin
            next_s.wr = 1'b1;
            next_s.reader_side_lock = 1'b1;
            next_s.addr = {1'b0, s.page};
            next_s.wdata = {s.word[23:0], rx_byte_in};
            next_s.page = s.page + 8'h01;
          end
        end
        if (rx_end_in) begin
          next_s.cnt = '0;
          next_s.burst_ok = 1'b0;
          next_s.resp_go = 1'b1;
          next_s.st = nca_pkg::NCA_REPLY;
          next_s.code = nca_pkg::NAK_INVALID;
          if (!rx_crc_ok_in) begin
            // Corrupt frames get no answer at all
            next_s.st = nca_pkg::NCA_IDLE;
          end else if (s.st == nca_pkg::NCA_SW2) begin
            next_s.sw_pending = 1'b0;
            if (s.cnt == nca_pkg::LEN_SW2 && (s.op == 8'h00 || (s.op == 8'h01 &&
                large_variant_in))) begin
              next_s.sector = s.op[0];
              next_s.quiet_go = 1'b1;
              next_s.st = nca_pkg::NCA_QUIET;
            end
          end else if (s.op == nca_pkg::OP_MULTI_READ && s.cnt == nca_pkg::LEN_READ) begin
            next_s.page = s.a1;
            next_s.last = s.a2;
            if (s.i2c_lock && !sess_pg(s.sector, s.a1)) begin
              next_s.code = nca_pkg::NAK_ARBITER;
            end else if (rd_ok(s.sector, s.a1, pthru_on_in, large_variant_in) &&
                         s.a2 >= s.a1) begin
              next_s.reader_side_lock = !s.i2c_lock;
              next_s.st = nca_pkg::NCA_FETCH;
            end
            // Otherwise a bad start page refuses the whole read
          end else if (s.op == nca_pkg::OP_PAGE_WRITE && s.cnt == nca_pkg::LEN_WRITE) begin
            if (s.i2c_lock) begin
              next_s.code = nca_pkg::NAK_ARBITER;
            end else if (wr_ok(s.sector, s.a1, pthru_on_in, large_variant_in)) begin
              next_s.reader_side_lock = 1'b1;
              next_s.addr = {s.sector, s.a1};
              next_s.wdata = s.word;
              next_s.st = nca_pkg::NCA_WCHK;
            end
          end else if (s.op == nca_pkg::OP_SRAM_BURST) begin
            if (s.i2c_lock) begin
              next_s.code = nca_pkg::NAK_ARBITER;
            end else if (s.burst_ok && s.cnt == nca_pkg::LEN_BURST) begin
              next_s.code = nca_pkg::RESP_ACK;
            end
          end else if (s.op == nca_pkg::OP_SECTOR_SW && s.cnt == nca_pkg::LEN_SW1 &&
                       s.a1 == nca_pkg::SECTOR_KEY) begin
            // Allowed even while the host holds memory
            next_s.code = nca_pkg::RESP_ACK;
            next_s.sw_pending = 1'b1;
          end
        end
      end
      nca_pkg::NCA_FETCH: begin
        if (rd_ok(s.sector, s.page, pthru_on_in, large_variant_in)) begin
          next_s.rd = 1'b1;
          next_s.addr = {s.sector, s.page};
          next_s.st = nca_pkg::NCA_WAIT;
        end else begin
          // Holes inside a read come back as zeros
          next_s.word = '0;
          next_s.bsel = '0;
          next_s.pv = 1'b1;
          next_s.pd = '0;
          next_s.st = nca_pkg::NCA_PUSH;
        end
      end
      nca_pkg::NCA_WAIT: next_s.st = nca_pkg::NCA_CAP;
      nca_pkg::NCA_CAP: begin
        next_s.word = mem_rd_data_in;
        next_s.bsel = '0;
        next_s.pv = 1'b1;
        next_s.pd = {1'b0, mem_rd_data_in[31:24]};
        next_s.st = nca_pkg::NCA_PUSH;
      end
      nca_pkg::NCA_PUSH: begin
        // Full buffer stalls here until the reader drains it
        if (s.pv && fq.wr_ready) begin
          next_s.bsel = s.bsel + 2'b01;
          if (s.bsel == 2'b11) begin
            // Every page from start to end, one unbroken answer
            next_s.page = s.page + 8'h01;
            next_s.st = (s.page == s.last) ? nca_pkg::NCA_DRAIN : nca_pkg::NCA_FETCH;
          end else begin
            next_s.word = {s.word[23:0], 8'h00};
            next_s.pv = 1'b1;
            next_s.pd = {1'b0, s.word[23:16]};
          end
        end
      end
      nca_pkg::NCA_WCHK: begin
        // Lock bits of the addressed page are visible now
        if (page_locked_in) begin
          next_s.code = nca_pkg::NAK_INVALID;
        end else begin
          next_s.wr = 1'b1;
          next_s.code = nca_pkg::RESP_ACK;
        end
        next_s.st = nca_pkg::NCA_REPLY;
      end
      nca_pkg::NCA_REPLY: begin
        next_s.pv = 1'b1;
        next_s.pd = {1'b1, 4'h0, s.code};
        next_s.st = nca_pkg::NCA_DRAIN;
      end
      nca_pkg::NCA_DRAIN: begin
        if (!s.pv && !fq.rd_valid && !s.tv) begin
          // Command finished: reader releases memory
          next_s.reader_side_lock = 1'b0;
          next_s.st = s.sw_pending ? nca_pkg::NCA_SW2 : nca_pkg::NCA_IDLE;
        end
      end
      nca_pkg::NCA_QUIET: begin
        // Frames during the silence are dropped
        if (quiet_done && !s.quiet_go) begin
          next_s.st = nca_pkg::NCA_IDLE;
        end
      end
      default: next_s.st = nca_pkg::NCA_IDLE;
    endcase
    // Output stage holds a byte until the link takes it
    if (pop && !s.flush) begin
      next_s.tv = 1'b1;
      next_s.td = fq.rd_data;
    end else if (tx_ready_in || s.flush) begin
      next_s.tv = 1'b0;
    end
    // Field loss or halt aborts everything, frees memory, empties the buffer
    if (!field_on_in || halt_in) begin
      next_s.reader_side_lock = nca_pkg::LOCK_RESET;
      next_s.st = nca_pkg::NCA_IDLE;
      next_s.cnt = '0;
      next_s.sw_pending = 1'b0;
      next_s.pv = 1'b0;
      next_s.tv = 1'b0;
      next_s.flush = 1'b1;
    end
    // Host lock: a new claim beats a release in the same cycle
    if (i2c_release_in) begin
      next_s.i2c_lock = 1'b0;
    end
    if (i2c_addr_match_in && !active_state_in && !next_s.reader_side_lock) begin
      next_s.i2c_lock = 1'b1;
    end
    next_s.i2c_nack = i2c_access_in && s.reader_side_lock && !i2c_reg_access_in;
  end

  // Register; both lock bits start clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  lock_exclusive_a: assert property (!(s.i2c_lock && s.reader_side_lock))
    else $error("both interfaces hold the memory");
  answer_delay_a: assert property ($rose(s.tv) |-> $past(resp_done))
    else $error("answer sent before minimum delay");
  write_range_a: assert property (s.wr |-> wr_ok(s.addr[8], s.addr[7:0],
    $past(pthru_on_in), $past(large_variant_in)) || $past(s.burst_ok))
    else $error("write outside permitted pages");
  write_lock_a: assert property (s.wr && $past(s.st) == nca_pkg::NCA_WCHK |->
    !$past(page_locked_in))
    else $error("locked page written");
  host_block_a: assert property (s.rd |->
    !s.i2c_lock || sess_pg(s.addr[8], s.addr[7:0]))
    else $error("memory read while host holds lock");
  host_nack_a: assert property (i2c_access_in && s.reader_side_lock && !i2c_reg_access_in
    |=> i2c_nack_out)
    else $error("host access not refused");
  host_reg_a: assert property (i2c_access_in && i2c_reg_access_in |=> !i2c_nack_out)
    else $error("register access refused");
  field_clear_a: assert property (!field_on_in |=> !reader_side_lock_out)
    else $error("reader lock kept after field loss");
  host_claim_a: assert property (i2c_addr_match_in && !active_state_in &&
    !s.reader_side_lock && !s.i2c_lock && s.st == nca_pkg::NCA_IDLE |=> i2c_lock_out)
    else $error("host lock not taken");
  quiet_hold_a: assert property ($rose(s.st == nca_pkg::NCA_QUIET) |-> !s.tv[*8])
    else $error("answer during switch silence");
endmodule // nca_arbiter

// file: verif/nca_mem_model.sv
// Memory stand-in on the far side of the arbiter's memory port.
// Assumes registered read strobe and address from the arbiter.
`timescale 1ns/1ps
module nca_mem_model (
  input wire logic clk_in,
  input wire logic mem_rd_in,
  input wire logic [8:0] addr_in,
  output logic [31:0] rd_data_out,
  output logic locked_out
);
  // ==========
  // Page number in all four bytes; flips when idle so stale data never looks valid
  always_ff @(posedge clk_in) begin
    rd_data_out <= mem_rd_in ? {4{addr_in[7:0]}} : ~rd_data_out;
  end
  // Page 05 is write protected
  assign locked_out = (addr_in == 9'h005);
endmodule // nca_mem_model

// file: verif/test_nca_arbiter.sv
// Self-checking bench for the contactless command arbiter.
// Assumes the memory stand-in of nca_mem_model.sv.
`timescale 1ns/1ps
module test_nca_arbiter;
  logic clk_in = 0, resetn_in = 0, rx_valid_in = 0, rx_end_in = 0, tx_ready_in = 0, act = 0;
  logic fld_on = 1, halt = 0, big = 0, sec;
  logic match = 0, rel = 0, acc = 0, reg_acc = 0, nk, nr, tx_valid_out, tx_nibble_out;
  logic mem_rd_out, mem_wr_out, i2c_nack_out, i2c_lock_out, rl, locked;
  logic [7:0] rx_byte_in = 8'h00, tx_data_out;
  logic [8:0] mem_addr_out, wa;
  logic [31:0] rd_data, mem_wdata_out, wd;
  logic [8:0] got[$];
  int miscompares = 0, tests_run = 0, wrs = 0, first;
  nca_arbiter #(.RESP_CYC(20), .QUIET_CYC(40)) u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in), .rx_end_in(rx_end_in),
    .rx_crc_ok_in(1'b1), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_nibble_out(tx_nibble_out), .field_on_in(fld_on),
    .halt_in(halt), .active_state_in(act), .pthru_on_in(1'b0), .large_variant_in(big),
    .mem_rd_data_in(rd_data), .page_locked_in(locked), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .i2c_addr_match_in(match), .i2c_release_in(rel), .i2c_access_in(acc),
    .i2c_reg_access_in(reg_acc), .i2c_nack_out(i2c_nack_out), .i2c_lock_out(i2c_lock_out),
    .reader_side_lock_out(rl), .sector_out(sec));
  nca_mem_model u_mem (.clk_in(clk_in), .mem_rd_in(mem_rd_out), .addr_in(mem_addr_out),
    .rd_data_out(rd_data), .locked_out(locked));
  // ==========
  // Clock, write monitor off the active edge to avoid races
  initial forever #10 clk_in = ~clk_in;
  always @(negedge clk_in) if (mem_wr_out === 1'b1) begin
    wrs++;
    wa = mem_addr_out;
    wd = mem_wdata_out;
  end
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic send(input logic [47:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rx_valid_in = 1;
      rx_byte_in = f[i*8 +: 8];
      @(posedge clk_in) #1;
    end
    rx_valid_in = 0;
    rx_end_in = 1;
    @(posedge clk_in) #1;
    rx_end_in = 0;
  endtask
  // Collects the answer; stalls the link, probes the host port before the answer starts
  task automatic recv(input int stall);
    first = -1;
    got.delete();
    for (int c = 0; c < 300; c++) begin
      tx_ready_in = (c >= stall);
      acc = (c == 10 || c == 14);
      reg_acc = (c == 14);
      if (c == 11) nk = i2c_nack_out;
      if (c == 15) nr = i2c_nack_out;
      if (tx_valid_out === 1'b1 && first < 0) first = c;
      if (tx_valid_out === 1'b1 && tx_ready_in) got.push_back({tx_nibble_out, tx_data_out});
      @(posedge clk_in) #1;
    end
    tx_ready_in = 0;
    chk(first >= 20, 1);
  endtask
  task automatic read_chk(input int s, e, stall);
    logic [8:0] ex[$];
    send({8'h3A, s[7:0], e[7:0]}, 3);
    recv(stall);
    if (s > 'hE9 && s != 'hEC && s != 'hED) ex.push_back(9'h100);
    else for (int p = s; p <= e; p++) repeat (4) ex.push_back((p <= 'hE9 || p > 'hEB) ? p : 0);
    chk(got.size(), ex.size());
    foreach (ex[i]) chk(got[i], ex[i]);
  endtask
  task automatic wr_chk(input logic [7:0] pg, input logic [8:0] ans, input int dw);
    int w0 = wrs;
    send({8'hA2, pg, 32'h1122_3344}, 6);
    recv(0);
    chk(got.size(), 1);
    chk(got[0], ans);
    chk(wrs - w0, dw);
    if (dw == 1) chk(wa, {1'b0, pg});
    if (dw == 1) chk(wd, 32'h1122_3344);
  endtask
  // Stalled read cut by halt or field loss; the next read must carry no stale bytes
  task automatic abort_chk(input logic by_halt);
    send({8'h3A, 8'h00, 8'h03}, 3);
    repeat (30) @(posedge clk_in) #1;
    chk(rl, 1);
    halt = by_halt;
    fld_on = by_halt;
    @(posedge clk_in) #1;
    halt = 0;
    fld_on = 1;
    chk({rl, tx_valid_out}, 0);
    repeat (10) @(posedge clk_in) #1;
    read_chk('hEC, 'hED, 0);
  endtask
  // Two-packet switch: acknowledge, then silence and the new sector
  task automatic sw_chk(input logic [7:0] sn);
    int n = 0;
    send({8'hC2, 8'hFF}, 2);
    recv(0);
    chk(got.size(), 1);
    chk(got[0], 9'h10A);
    send({sn, 24'h00_0000}, 4);
    repeat (60) begin
      n += (tx_valid_out !== 1'b0);
      @(posedge clk_in) #1;
    end
    chk(n, 0);
    chk(sec, sn[0]);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #150000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    #1 resetn_in = 1;
    chk({i2c_lock_out, rl}, 0);
    read_chk('hE8, 'hEA, 40);
    chk({nk, nr}, 2'b10);
    read_chk('hEC, 'hED, 0);
    read_chk('hEA, 'hEB, 0);
    $display("read test done");
    wr_chk(8'h02, 9'h10A, 1);
    wr_chk(8'h01, 9'h100, 0);
    wr_chk(8'h05, 9'h100, 0);
    $display("write test done");
    match = 1;
    @(posedge clk_in) #1 match = 0;
    chk(i2c_lock_out, 1);
    wr_chk(8'h04, 9'h104, 0);
    read_chk('hEC, 'hEC, 0);
    rel = 1;
    @(posedge clk_in) #1 rel = 0;
    @(posedge clk_in) #1 chk(i2c_lock_out, 0);
    $display("host test done");
    abort_chk(1);
    abort_chk(0);
    $display("abort test done");
    big = 1;
    sw_chk(8'h01);
    sw_chk(8'h00);
    $display("sector test done");
    conclude();
  end
endmodule // test_nca_arbiter
